// ### hdl/shared_prescaler.sv
/*
 Eight-bit prescaler shared between the timer and the watchdog.
 Assumes count_i and clear_i are one-cycle pulses synchronous to clock_i.
*/
module shared_prescaler
	import tmr_pkg::*;
#(
	parameter int WIDTH = 8
)(
	input  wire logic       clock_i,     // Oscillator clock
	input  wire logic       rst_n_i,     // Async reset, active low
	input  wire logic       clear_i,     // Clear the count
	input  wire logic       count_i,     // Count one source event
	input  wire logic [2:0] ratio_i,     // Ratio field
	output logic            tap_o,       // Timer tap, divide by 2^(ratio+1)
	output logic            carry_o      // Watchdog pulse, divide by 2^ratio
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;
	logic [WIDTH-1:0] low_mask;

	// Clear wins over a count so a write never leaves a stale partial count
	always_comb
	begin
		cnt_next = cnt_reg;
		if (clear_i)
			cnt_next = '0;
		else if (count_i)
			cnt_next = cnt_reg + 1'b1;
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	// Tap bit toggles symmetrically, so the sampled output has equal halves
	assign tap_o    = cnt_reg[ratio_i];
	assign low_mask = WIDTH'((1 << ratio_i) - 1);
	assign carry_o  = count_i & ((cnt_reg & low_mask) == low_mask);
endmodule : shared_prescaler

// ### hdl/timer_counter.sv
/*
 Eight-bit timer/counter with source select, edge select, shared prescaler,
 overflow flag and an APB slave for its registers.
 Assumes APB signals and the count pin are synchronous to clock_i (25 MHz).
*/
// Behaviour
// - Source select clear: timer mode, count once per instruction cycle undivided
// - After writing the count, increments are suppressed for two instruction cycles
// - Source select set: counter mode, count selected edges of the count pin
// - Edge select clear counts rising edges, set counts falling edges
// - One prescaler; assign bit gives it to timer (0) or watchdog (1)
// - Timer ratio 1:2 to 1:256 in powers of two
// - Prescaler count is neither readable nor writable
// - Wrap from FFh to 00h sets the overflow flag
// - Overflow request passes only when its enable bit is set
// - Timer stops in sleep, so overflow cannot wake the core
// - Prescaler output or raw pin is sampled on Q2 and Q4
// - Count increments 2 to 4 oscillator periods after a pin edge
// - Prescaler is an 8-bit counter whose output is symmetrical
// - With timer assignment, writing the count clears the prescaler
// - With watchdog assignment, watchdog clear also clears the prescaler
// - Watchdog assignment gives postscale ratios up to 1:128
// - Sleep or watchdog clear clears the watchdog and its prescaler
module timer_counter
	import tmr_pkg::*;
(
	input  wire logic              clock_i,        // Oscillator clock
	input  wire logic              rst_n_i,        // Async reset, active low
	input  wire logic              psel_i,         // APB select
	input  wire logic              penable_i,      // APB enable
	input  wire logic              pwrite_i,       // APB direction
	input  wire logic [ADDR_W-1:0] paddr_i,        // APB byte address
	input  wire logic [31:0]       pwdata_i,       // APB write data
	output logic      [31:0]       prdata_o,       // APB read data
	output logic                   pready_o,       // APB ready
	output logic                   pslverr_o,      // APB error
	input  wire logic              count_input_pin_i, // External count input
	input  wire logic              wdt_tick_i,     // Watchdog oscillator tick
	output logic                   wdt_scaled_tick_o, // Postscaled watchdog tick
	output logic                   wdt_clear_o,    // Watchdog counter clear pulse
	output logic                   overflow_irq_o, // Masked overflow request
	output logic                   sleeping_o,     // Core asleep
	output logic      [7:0]        port_a_direction_o // Port A direction bits
);
	// Index decode, used by the read and the write paths
	function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[9:2];
		decode = {(a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0), idx};
	endfunction : decode

	logic [7:0]  count_reg,   count_next;
	logic [7:0]  interrupt_control_reg,  interrupt_control_next;
	option_t     option_reg,  option_next;
	logic [7:0]  porta_reg,   porta_next;
	logic        sleep_reg,   sleep_next;
	logic [1:0]  phase_reg,   phase_next;
	logic [1:0]  inhibit_reg, inhibit_next;
	logic        sync_reg,    sync_next;
	logic        rise_reg,    rise_next;
	logic        pin_reg,     pin_next;
	logic [31:0] rdata_reg,   rdata_next;
	logic [8:0]  dec;
	logic        setup, access, wr, mapped;
	logic        wr_count, wr_interrupt_control, wr_option, wr_porta, wr_event;
	logic        inst_tick, q_sample, sel_level, sel_edge, inc, wrap;
	logic        ps_count, ps_clear, ps_tap, ps_carry, core_clear;

	// Edge history leaves reset at the level an idle-low pin gives under the reset edge
	// choice, so the first cycles after reset never look like a counted edge
	localparam option_t OPT_AT_RESET = option_t'(RST_OPTION_CFG);

	// Bus decode; APB answers with no wait state
	assign dec       = decode(paddr_i);
	assign mapped    = dec[8] && (dec[7:0] == IDX_TIMER_COUNT || dec[7:0] == IDX_INT_CONTROL
	                 || dec[7:0] == IDX_OPTION_CFG || dec[7:0] == IDX_PORTA_DIR
	                 || dec[7:0] == IDX_CORE_EVENT);
	assign setup     = psel_i & ~penable_i;
	assign access    = psel_i & penable_i;
	assign wr        = access & pwrite_i & mapped;
	assign wr_count  = wr & (dec[7:0] == IDX_TIMER_COUNT);
	assign wr_interrupt_control = wr & (dec[7:0] == IDX_INT_CONTROL);
	assign wr_option = wr & (dec[7:0] == IDX_OPTION_CFG);
	assign wr_porta  = wr & (dec[7:0] == IDX_PORTA_DIR);
	assign wr_event  = wr & (dec[7:0] == IDX_CORE_EVENT);
	assign pready_o  = access;
	assign pslverr_o = access & ~mapped;
	assign prdata_o  = rdata_reg;

	// Read data captured in the setup phase so it leaves a flip-flop.
	// The prescaler has no read path at all.
	always_comb
	begin
		rdata_next = rdata_reg;
		if (setup)
		begin
			rdata_next = '0;
			if (dec[8])
				case (dec[7:0])
					IDX_TIMER_COUNT: rdata_next = {24'h00_0000, count_reg};
					IDX_INT_CONTROL: rdata_next = {24'h00_0000, interrupt_control_reg};
					IDX_OPTION_CFG:  rdata_next = {24'h00_0000, option_reg};
					IDX_PORTA_DIR:   rdata_next = {24'h00_0000, porta_reg};
					IDX_CORE_EVENT:  rdata_next = {31'h0000_0000, sleep_reg};
					default:         rdata_next = '0;
				endcase
		end
	end

	// Phase counter: Q2 and Q4 sample, end of Q4 closes the instruction cycle
	assign phase_next = phase_reg + 2'h1;
	assign inst_tick  = (phase_reg == PHASE_Q4);
	assign q_sample   = (phase_reg == PHASE_Q2) || (phase_reg == PHASE_Q4);

	// Edge select folds into an inversion, so a rise is always the counted edge
	assign sel_level = count_input_pin_i ^ option_reg.source_edge_select;
	assign pin_next  = sel_level;
	assign sel_edge  = sel_level & ~pin_reg;

	// Prescaler source and clear follow the assignment bit of the last cycle
	always_comb
	begin
		core_clear = wr_event & (pwdata_i[POS_SLEEP] | pwdata_i[POS_WDT_CLEAR]);
		if (!option_reg.prescaler_assign)
		begin
			ps_count = ~sleep_reg & (option_reg.clock_source_select ? sel_edge : inst_tick);
			ps_clear = wr_count;
		end
		else
		begin
			ps_count = wdt_tick_i;
			ps_clear = core_clear;
		end
	end

	shared_prescaler #(
		.WIDTH   (8)
	) u_prescaler (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.clear_i (ps_clear),
		.count_i (ps_count),
		.ratio_i (option_reg.prescale_ratio_field),
		.tap_o   (ps_tap),
		.carry_o (ps_carry)
	);

	// Watchdog sees the postscaled tick only while it owns the prescaler
	assign wdt_scaled_tick_o = option_reg.prescaler_assign ? ps_carry : wdt_tick_i;
	assign wdt_clear_o       = core_clear;

	// Sampled source: prescaler tap, or the raw edge-selected pin undivided
	always_comb
	begin
		sync_next = sync_reg;
		rise_next = 1'b0;
		if (q_sample)
		begin
			sync_next = option_reg.prescaler_assign ? sel_level : ps_tap;
			rise_next = sync_next & ~sync_reg;
		end
	end

	// Increment source; sleep stops both modes
	always_comb
	begin
		if (!option_reg.clock_source_select && option_reg.prescaler_assign)
			inc = inst_tick;
		else
			inc = rise_reg;
		inc = inc & ~sleep_reg & (inhibit_reg == 2'h0);
	end
	assign wrap = inc & (count_reg == COUNT_MAX);

	// Write inhibit counts down whole instruction cycles
	always_comb
	begin
		inhibit_next = inhibit_reg;
		if (wr_count)
			inhibit_next = WRITE_INHIBIT;
		else if (inst_tick && inhibit_reg != 2'h0)
			inhibit_next = inhibit_reg - 2'h1;
	end

	// Register file; a write beats an increment in the same cycle
	always_comb
	begin
		count_next  = count_reg;
		interrupt_control_next = interrupt_control_reg;
		option_next = option_reg;
		porta_next  = porta_reg;
		sleep_next  = sleep_reg;
		if (wr_count)
			count_next = pwdata_i[7:0];
		else if (inc)
			count_next = count_reg + 8'h01;
		if (wr_interrupt_control)
			interrupt_control_next = pwdata_i[7:0];
		// Set wins over a software clear in the same cycle
		if (wrap)
			interrupt_control_next[POS_OVF_FLAG] = 1'b1;
		if (wr_option)
			option_next = option_t'(pwdata_i[7:0]);
		if (wr_porta)
			porta_next = pwdata_i[7:0] & PORTA_DIR_MASK;
		if (wr_event)
			sleep_next = pwdata_i[POS_SLEEP];
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_reg   <= RST_TIMER_COUNT;
			interrupt_control_reg  <= RST_INT_CONTROL;
			option_reg  <= option_t'(RST_OPTION_CFG);
			porta_reg   <= RST_PORTA_DIR;
			sleep_reg   <= 1'b0;
			phase_reg   <= 2'h0;
			inhibit_reg <= 2'h0;
			sync_reg    <= OPT_AT_RESET.source_edge_select;
			rise_reg    <= 1'b0;
			pin_reg     <= OPT_AT_RESET.source_edge_select;
			rdata_reg   <= '0;
		end
		else
		begin
			count_reg   <= count_next;
			interrupt_control_reg  <= interrupt_control_next;
			option_reg  <= option_next;
			porta_reg   <= porta_next;
			sleep_reg   <= sleep_next;
			phase_reg   <= phase_next;
			inhibit_reg <= inhibit_next;
			sync_reg    <= sync_next;
			rise_reg    <= rise_next;
			pin_reg     <= pin_next;
			rdata_reg   <= rdata_next;
		end
	end

	// Request masked by the enable; global enable is the core's business
	assign overflow_irq_o     = interrupt_control_reg[POS_OVF_FLAG] & interrupt_control_reg[POS_OVF_IE];
	assign sleeping_o         = sleep_reg;
	assign port_a_direction_o = porta_reg;

	// Checks
	sequence s_timer_step;
		!wr_count && inc;
	endsequence

	// Undivided pin edge with the option settled long enough for the sampler to agree
	sequence s_pin_edge;
		sel_edge && option_reg.clock_source_select && option_reg.prescaler_assign
		&& !wr_option && $stable(option_reg) && $past(option_reg, 2) == option_reg;
	endsequence

	chk_timer_step: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		s_timer_step |=> count_reg == $past(count_reg) + 8'h01)
		else $error("count did not advance on an increment");
	chk_write_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_count |=> (inhibit_reg == 2'h2) ##1 (!inc throughout (inhibit_reg != 2'h0)[*1]))
		else $error("increment not held off after a count write");
	chk_inhibit_end: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_count && !sleep_reg |=> ##[1:9] inhibit_reg == 2'h0)
		else $error("write inhibit lasted too long");
	chk_wrap_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wrap && !wr_count |=> count_reg == 8'h00 && interrupt_control_reg[POS_OVF_FLAG])
		else $error("wrap did not set the overflow flag");
	chk_irq_mask: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!interrupt_control_reg[POS_OVF_IE] |-> !overflow_irq_o)
		else $error("masked overflow request passed");
	chk_flag_kept: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		interrupt_control_reg[POS_OVF_FLAG] && !wr_interrupt_control |=> interrupt_control_reg[POS_OVF_FLAG])
		else $error("overflow flag cleared by hardware");
	chk_sleep_stop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		sleep_reg && !wr_count |=> $stable(count_reg))
		else $error("count moved during sleep");
	chk_sample_phase: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!$stable(sync_reg) |-> $past(q_sample))
		else $error("source sampled outside Q2 and Q4");
	chk_clear_timer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_count && !option_reg.prescaler_assign |=> u_prescaler.cnt_reg == 8'h00)
		else $error("count write did not clear the prescaler");
	chk_clear_wdt: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		core_clear && option_reg.prescaler_assign |=> u_prescaler.cnt_reg == 8'h00)
		else $error("watchdog clear did not clear the prescaler");
	chk_option_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_option |=> option_reg == $past(pwdata_i[7:0]))
		else $error("option write not in effect on the next cycle");
	chk_edge_delay: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		s_pin_edge |-> ##[1:2] rise_reg)
		else $error("pin edge not sampled within two clocks");
	chk_irq_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		interrupt_control_reg[POS_OVF_IE] && interrupt_control_reg[POS_OVF_FLAG] |-> overflow_irq_o)
		else $error("enabled overflow request not passed");
	chk_timer_rate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!option_reg.clock_source_select && option_reg.prescaler_assign && !inst_tick
		&& !wr_count |=> $stable(count_reg))
		else $error("undivided timer moved between instruction ticks");
endmodule : timer_counter

// ### hdl/tmr_pkg.sv
/*
 Shared constants and carriers for the 8-bit timer/counter with its shared prescaler.
 Assumes a single 25 MHz oscillator clock; four clocks form one instruction cycle.
*/
package tmr_pkg;
	// Register indices; byte address on APB is four times the index
	localparam logic [7:0]  IDX_TIMER_COUNT = 8'h01;
	localparam logic [7:0]  IDX_INT_CONTROL = 8'h0b;
	localparam logic [7:0]  IDX_OPTION_CFG  = 8'h81;
	localparam logic [7:0]  IDX_PORTA_DIR   = 8'h85;
	localparam logic [7:0]  IDX_CORE_EVENT  = 8'h90;
	localparam int          ADDR_W          = 12;
	// Reset values
	localparam logic [7:0]  RST_TIMER_COUNT = 8'h00;
	localparam logic [7:0]  RST_INT_CONTROL = 8'h00;
	localparam logic [7:0]  RST_OPTION_CFG  = 8'hff;
	localparam logic [7:0]  RST_PORTA_DIR   = 8'h1f;
	localparam logic [7:0]  PORTA_DIR_MASK  = 8'h1f;
	// Field positions in interrupt_control
	localparam int          POS_GIE         = 7;
	localparam int          POS_OVF_IE      = 5;
	localparam int          POS_OVF_FLAG    = 2;
	// Field positions in the core event register
	localparam int          POS_SLEEP       = 0;
	localparam int          POS_WDT_CLEAR   = 1;
	// Instruction cycle: four oscillator phases Q1..Q4
	localparam logic [1:0]  PHASE_Q2        = 2'h1;
	localparam logic [1:0]  PHASE_Q4        = 2'h3;
	// Write inhibit of the count, in instruction cycles
	localparam logic [1:0]  WRITE_INHIBIT   = 2'h2;
	localparam logic [7:0]  COUNT_MAX       = 8'hff;

	// Option register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       pull_up_off;
		logic       int_edge;
		logic       clock_source_select;
		logic       source_edge_select;
		logic       prescaler_assign;
		logic [2:0] prescale_ratio_field;
	} option_t;
endpackage : tmr_pkg

// ### verif/pulse_source.sv
/*
 Partner model: an external pulse source driving the count input pin.
 Assumes the bench calls its tasks and shares the 25 MHz oscillator clock.
*/
module pulse_source
(
	input  wire logic clock_i, // Oscillator clock
	output logic      pin_o    // Count input pin level
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle low between bursts, so no stray edge reaches the counter
	initial pin_o = 1'b0;

	// Each level held at least three clocks: 120 ns beats 2Tosc plus 20 ns, and 10 ns
	task automatic burst(input int rises, input bit stay_high);
		for (int i = 0; i < rises; i++)
		begin
			@(posedge clock_i);
			pin_o <= 1'b1;
			repeat (3) @(posedge clock_i);
			if (i < rises - 1 || !stay_high)
			begin
				pin_o <= 1'b0;
				repeat (3) @(posedge clock_i);
			end
		end
	endtask : burst

	// Return to idle after a burst that ended high
	task automatic drop();
		@(posedge clock_i);
		pin_o <= 1'b0;
		repeat (3) @(posedge clock_i);
	endtask : drop
endmodule : pulse_source

// ### verif/timer_counter_bench.sv
/*
 Self-checking bench for the timer/counter: APB tasks and a scenario sequence.
 Assumes a zero-wait APB slave and the pulse source model on the count pin.
*/
module timer_counter_bench
	import tmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [ADDR_W-1:0] A_CNT = ADDR_W'({IDX_TIMER_COUNT, 2'b00});
	localparam logic [ADDR_W-1:0] A_INT = ADDR_W'({IDX_INT_CONTROL, 2'b00});
	localparam logic [ADDR_W-1:0] A_OPT = ADDR_W'({IDX_OPTION_CFG, 2'b00});
	localparam logic [ADDR_W-1:0] A_PTA = ADDR_W'({IDX_PORTA_DIR, 2'b00});
	localparam logic [ADDR_W-1:0] A_EVT = ADDR_W'({IDX_CORE_EVENT, 2'b00});

	logic              clock, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, q, v;
	logic              pin, wdt_tick, wdt_scaled, wdt_clear, irq, sleeping, e;
	logic [7:0]        porta_dir;
	int                num_errors = 0;
	int                n_tests = 0;
	int                n_scaled = 0;
	int                n_clears = 0;

	timer_counter dut (.clock_i(clock), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .count_input_pin_i(pin),
		.wdt_tick_i(wdt_tick), .wdt_scaled_tick_o(wdt_scaled), .wdt_clear_o(wdt_clear),
		.overflow_irq_o(irq), .sleeping_o(sleeping), .port_a_direction_o(porta_dir));

	pulse_source src (.clock_i(clock), .pin_o(pin));

	// 25 MHz oscillator
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Count postscaled watchdog pulses and watchdog clear pulses
	always @(posedge clock)
	begin
		if (wdt_scaled === 1'b1)
			n_scaled <= n_scaled + 1;
		if (wdt_clear === 1'b1)
			n_clears <= n_clears + 1;
	end

	// Range compare; an unknown never lands inside the range
	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		n_tests++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// Only the hang guard ends a wait that never sees pready
		while (pready !== 1'b1)
			@(posedge clock);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] lo, input logic [31:0] hi);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, lo, hi);
	endtask : rd

	// Watchdog oscillator ticks, one clock wide with a gap
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clock);
			wdt_tick <= 1'b1;
			@(posedge clock);
			wdt_tick <= 1'b0;
		end
		repeat (2) @(posedge clock);
	endtask : ticks

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// Hang guard, well beyond the roughly 17k clocks the sequence needs
	initial
	begin
		repeat (60000) @(posedge clock);
		num_errors++;
		test_done();
	end

	initial
	begin
		{rst_n, psel, penable, pwrite, wdt_tick} = 5'h00;
		paddr = '0;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		// Reset values, unmapped refusal, five-bit direction register
		rd(A_OPT, 8'hff, 8'hff);
		rd(A_PTA, 8'h1f, 8'h1f);
		rd(A_INT, 8'h00, 8'h00);
		rd(A_CNT, 8'h00, 8'h00);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk(e, 1'b1, 1'b1);
		wr(A_PTA, 32'h0000_00ff);
		rd(A_PTA, 8'h1f, 8'h1f);
		chk(porta_dir, 8'h1f, 8'h1f);
		// Undivided timer: two ticks lost after a count write
		wr(A_OPT, 32'h0000_0008);
		wr(A_CNT, 32'h0000_0010);
		repeat (40) @(posedge clock);
		rd(A_CNT, 8'h17, 8'h19);
		// Every timer ratio; the count write restarts the prescaler
		wr(A_EVT, 32'h0000_0002);
		for (int r = 0; r < 8; r++)
		begin
			wr(A_OPT, r);
			wr(A_CNT, 32'h0000_0000);
			repeat (64 << r) @(posedge clock);
			rd(A_CNT, 8'h06, 8'h09);
		end
		// Counter mode: five rises, pin left high, both edge choices
		for (int s = 0; s < 2; s++)
		begin
			wr(A_OPT, 32'h0000_0028 | (s << 4));
			wr(A_CNT, 32'h0000_0000);
			repeat (12) @(posedge clock);
			src.burst(5, 1'b1);
			repeat (8) @(posedge clock);
			rd(A_CNT, 5 - s, 5 - s);
			src.drop();
		end
		// Counter through the 1:2 prescaler
		wr(A_EVT, 32'h0000_0002);
		wr(A_OPT, 32'h0000_0020);
		wr(A_CNT, 32'h0000_0000);
		repeat (12) @(posedge clock);
		src.burst(8, 1'b0);
		repeat (8) @(posedge clock);
		rd(A_CNT, 8'h04, 8'h04);
		// Overflow sets the flag while masked; the mask gates the request
		wr(A_OPT, 32'h0000_0008);
		wr(A_INT, 32'h0000_0000);
		wr(A_CNT, 32'h0000_00fd);
		repeat (40) @(posedge clock);
		rd(A_INT, 8'h04, 8'h04);
		chk(irq, 1'b0, 1'b0);
		wr(A_INT, 32'h0000_0024);
		repeat (2) @(posedge clock);
		chk(irq, 1'b1, 1'b1);
		repeat (300) @(posedge clock);
		rd(A_INT, 8'h24, 8'h24);
		wr(A_INT, 32'h0000_0020);
		rd(A_INT, 8'h20, 8'h20);
		chk(irq, 1'b0, 1'b0);
		// Sleep freezes the count
		wr(A_EVT, 32'h0000_0001);
		@(posedge clock);
		chk(sleeping, 1'b1, 1'b1);
		apb(1'b0, A_CNT, 32'h0000_0000);
		v = q;
		repeat (40) @(posedge clock);
		rd(A_CNT, v, v);
		wr(A_EVT, 32'h0000_0000);
		// Watchdog postscaler ratios after a safe hand-over
		wr(A_CNT, 32'h0000_0000);
		wr(A_OPT, 32'h0000_000f);
		for (int r = 0; r < 4; r++)
		begin
			wr(A_OPT, 32'h0000_0008 | r);
			wr(A_EVT, 32'h0000_0002);
			v = n_scaled;
			ticks(16);
			chk(n_scaled - v, 16 >> r, 16 >> r);
		end
		// Prescaler on the timer: watchdog runs undivided
		wr(A_EVT, 32'h0000_0002);
		wr(A_OPT, 32'h0000_0003);
		v = n_scaled;
		ticks(16);
		chk(n_scaled - v, 16, 16);
		chk(n_clears, 8, 8);
		test_done();
	end
endmodule : timer_counter_bench
